// >>> core/pwlock_defs.svh
// opcodes, parameter-sector layout, register values and counts for the password lock block
`ifndef PWLOCK_DEFS_SVH
`define PWLOCK_DEFS_SVH
`define OPC_SET_PASSWORD 8'hF1
`define OPC_UNLOCK 8'hF2
`define SECTOR_WORDS 256
`define PW_FIRST_WORD 1
`define PW_WORDS 16
`define REV_WORD 17
`define CW_MASTER_BIT 0
`define CW_LEVEL_BIT 8
`define REV_INVALID_LO 16'h0000
`define REV_INVALID_HI 16'hFFFF
`define REV_RESET 16'h0000
`define ATTEMPTS_INIT 3'h5
`define ST_READY 8'h40
`define ST_XFER 8'h48
`define ST_BUSY 8'hC0
`define ST_ABORT 8'h41
`define ERR_NONE 8'h00
`define ERR_ABORT 8'h04
`endif

// >>> core/pwlock_pkg.sv
// types shared by the password lock block
`include "pwlock_defs.svh"
package pwlock_pkg;
   typedef enum logic [1:0] {
      CMD_IDLE,
      CMD_XFER,
      CMD_CHECK
   } cmd_state_t;
endpackage

// >>> core/sector_capture.sv
// parameter-sector receiver: counts words and keeps control word, password and revision code
`timescale 1ns/1ps
`default_nettype none
`include "pwlock_defs.svh"
module sector_capture #(
   parameter int WORDS = `SECTOR_WORDS
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // word stream
   input wire logic start,
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   // captured fields
   output logic last_word,
   output logic [15:0] ctrl_word,
   output logic [255:0] password,
   output logic [15:0] rev_code
);
   import pwlock_pkg::*;
   localparam int IW = $clog2(WORDS);
   logic [IW-1:0] word_idx;

   assign last_word = word_valid && (word_idx == IW'(WORDS - 1));

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         word_idx <= '0;
      else if (start)
         word_idx <= '0;
      else if (word_valid)
         word_idx <= word_idx + IW'(1);
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_word <= '0;
         rev_code <= '0;
      end
      else if (word_valid && word_idx == IW'(0))
         ctrl_word <= word_data;
      else if (word_valid && word_idx == IW'(`REV_WORD))
         rev_code <= word_data;
   end

   // all 32 password bytes kept, no terminator handling
   genvar g;
   generate
      for (g = 0; g < `PW_WORDS; g++)
      begin : gen_pw
         always_ff @(posedge sys_clk or negedge resetn)
         begin
            if (!resetn)
               password[g*16 +: 16] <= '0;
            else if (word_valid && word_idx == IW'(g + `PW_FIRST_WORD))
               password[g*16 +: 16] <= word_data;
         end
      end
   endgenerate
endmodule
`default_nettype wire

// >>> core/drive_password_set_unlock.sv
// password set and unlock command logic of the drive lock feature
`timescale 1ns/1ps
`default_nettype none
`include "pwlock_defs.svh"
// Behaviour
// - opcode F1h decodes as set password
// - user set enables lock, locks after power-on
// - master set stored, no lock after power-on
// - one parameter sector follows each command
// - word0 bit0 master, bit8 maximum level
// - password words 1-16, all 32 bytes
// - word17 master revision, shown as word 92
// - high user: user or master unlocks
// - master set never enables lock
// - maximum user: only user password unlocks
// - opcode F2h is unlock, same layout
// - unlock clears lock; reset relocks
// - master unlock: compare high, reject maximum
// - user unlock compares stored user password
// - counter from 5, mismatch aborts, decrements
// - counter zero rejects until reset
// - lock disabled plus user unlock aborts
// - after sector mismatch or refused unlock (master at maximum, user with lock disabled) aborts
// - frozen rejects both commands
module drive_password_set_unlock #(
   parameter int SECTOR_WORDS = `SECTOR_WORDS
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // command register write
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   // parameter data words from host
   input wire logic data_valid,
   input wire logic [15:0] data_word,
   // drive events
   input wire logic power_on_pulse,
   input wire logic hard_reset_pulse,
   input wire logic frozen,
   // task file answer registers
   output logic [7:0] command_error_flags,
   output logic [7:0] command_status_flags,
   // lock state
   output logic [15:0] identify_word92,
   output logic lock_enabled,
   output logic drive_locked,
   output logic level_max,
   output logic [2:0] attempts_left
);
   import pwlock_pkg::*;

   cmd_state_t state;
   logic cmd_is_set;
   logic lock_armed;
   logic [255:0] user_pw;
   logic [255:0] master_pw;
   logic last_word;
   logic [15:0] ctrl_word;
   logic [255:0] rx_pw;
   logic [15:0] rx_rev;
   logic cmd_hit;
   logic pre_reject;
   logic flag_master;
   logic unlock_refused;
   logic pw_ok;
   logic mismatch;
   logic abort_now;
   logic chk_set;
   logic chk_unlock;
   logic any_reset;

   assign any_reset = power_on_pulse || hard_reset_pulse;
   assign cmd_hit = (state == CMD_IDLE) && cmd_valid &&
      (cmd_code == `OPC_SET_PASSWORD || cmd_code == `OPC_UNLOCK);
   assign pre_reject = frozen || (attempts_left == 3'h0);
   assign flag_master = ctrl_word[`CW_MASTER_BIT];
   assign chk_set = (state == CMD_CHECK) && cmd_is_set;
   assign chk_unlock = (state == CMD_CHECK) && !cmd_is_set;
   // maximum level shuts out master; disabled lock shuts out user
   assign unlock_refused = flag_master ? level_max : !lock_enabled;
   assign pw_ok = flag_master ? (rx_pw == master_pw) : (rx_pw == user_pw);
   assign mismatch = chk_unlock && !unlock_refused && !pw_ok;
   assign abort_now = (chk_unlock && unlock_refused) || mismatch;

   sector_capture #(
      .WORDS(SECTOR_WORDS)
   ) u_capture (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .start(cmd_hit),
      .word_valid(data_valid && state == CMD_XFER),
      .word_data(data_word),
      .last_word(last_word),
      .ctrl_word(ctrl_word),
      .password(rx_pw),
      .rev_code(rx_rev)
   );

   // command sequencing
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         state <= CMD_IDLE;
      else if (any_reset)
         state <= CMD_IDLE;
      else
      begin
         unique case (state)
            CMD_IDLE:
               if (cmd_hit && !pre_reject)
                  state <= CMD_XFER;
            CMD_XFER:
               if (last_word)
                  state <= CMD_CHECK;
            CMD_CHECK:
               state <= CMD_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         cmd_is_set <= 1'b0;
      else if (cmd_hit)
         cmd_is_set <= (cmd_code == `OPC_SET_PASSWORD);
   end

   // answer registers
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         command_status_flags <= `ST_READY;
         command_error_flags <= `ERR_NONE;
      end
      else if (any_reset)
      begin
         command_status_flags <= `ST_READY;
         command_error_flags <= `ERR_NONE;
      end
      else if (cmd_hit && pre_reject)
      begin
         command_status_flags <= `ST_ABORT;
         command_error_flags <= `ERR_ABORT;
      end
      else if (cmd_hit)
      begin
         command_status_flags <= `ST_XFER;
         command_error_flags <= `ERR_NONE;
      end
      else if (state == CMD_XFER && last_word)
         command_status_flags <= `ST_BUSY;
      else if (state == CMD_CHECK)
      begin
         command_status_flags <= abort_now ? `ST_ABORT : `ST_READY;
         command_error_flags <= abort_now ? `ERR_ABORT : `ERR_NONE;
      end
   end

   // password store
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         user_pw <= '0;
         master_pw <= '0;
         identify_word92 <= `REV_RESET;
      end
      else if (chk_set && flag_master)
      begin
         master_pw <= rx_pw;
         if (rx_rev != `REV_INVALID_LO && rx_rev != `REV_INVALID_HI)
            identify_word92 <= rx_rev;
      end
      else if (chk_set)
         user_pw <= rx_pw;
   end

   // lock feature and level
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lock_enabled <= 1'b0;
         level_max <= 1'b0;
      end
      else if (chk_set && !flag_master)
      begin
         lock_enabled <= 1'b1;
         level_max <= ctrl_word[`CW_LEVEL_BIT];
      end
   end

   // lock engages only after power-on; hard reset relocks an armed drive
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lock_armed <= 1'b0;
         drive_locked <= 1'b0;
      end
      else if (power_on_pulse)
      begin
         lock_armed <= lock_enabled;
         drive_locked <= lock_enabled;
      end
      else if (hard_reset_pulse)
         drive_locked <= lock_armed;
      else if (chk_unlock && !abort_now)
         drive_locked <= 1'b0;
   end

   // unlock attempt counter
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         attempts_left <= `ATTEMPTS_INIT;
      else if (any_reset)
         attempts_left <= `ATTEMPTS_INIT;
      else if (mismatch && attempts_left != 3'h0)
         attempts_left <= attempts_left - 3'h1;
   end

   // checks
   sequence s_cmd_go(logic [7:0] op);
      state == CMD_IDLE && cmd_valid && cmd_code == op && !frozen && attempts_left != 3'h0 && !any_reset;
   endsequence

   sequence s_aborted;
      command_status_flags == `ST_ABORT && command_error_flags == `ERR_ABORT;
   endsequence

   property p_set_decode;
      @(posedge sys_clk) disable iff (!resetn)
      s_cmd_go(`OPC_SET_PASSWORD) |=> state == CMD_XFER && cmd_is_set && command_status_flags == `ST_XFER;
   endproperty
   a_set_decode: assert property (p_set_decode) else $error("set password not decoded");

   property p_unlock_decode;
      @(posedge sys_clk) disable iff (!resetn)
      s_cmd_go(`OPC_UNLOCK) |=> state == CMD_XFER && !cmd_is_set;
   endproperty
   a_unlock_decode: assert property (p_unlock_decode) else $error("unlock not decoded");

   property p_frozen_reject;
      @(posedge sys_clk) disable iff (!resetn)
      cmd_hit && frozen && !any_reset |=> s_aborted and state == CMD_IDLE;
   endproperty
   a_frozen_reject: assert property (p_frozen_reject) else $error("frozen drive took a command");

   property p_zero_reject;
      @(posedge sys_clk) disable iff (!resetn)
      cmd_hit && attempts_left == 3'h0 && !any_reset |=> s_aborted and state == CMD_IDLE;
   endproperty
   a_zero_reject: assert property (p_zero_reject) else $error("exhausted counter did not reject");

   property p_master_set_no_enable;
      @(posedge sys_clk) disable iff (!resetn)
      chk_set && flag_master && !any_reset |=> lock_enabled == $past(lock_enabled) && master_pw == $past(rx_pw);
   endproperty
   a_master_set_no_enable: assert property (p_master_set_no_enable) else $error("master set changed lock");

   property p_user_set_no_lock;
      @(posedge sys_clk) disable iff (!resetn)
      chk_set && !flag_master && !any_reset |=> lock_enabled && drive_locked == $past(drive_locked);
   endproperty
   a_user_set_no_lock: assert property (p_user_set_no_lock) else $error("user set locked at once");

   property p_rev_keep;
      @(posedge sys_clk) disable iff (!resetn)
      chk_set && (rx_rev == `REV_INVALID_LO || rx_rev == `REV_INVALID_HI) |=> $stable(identify_word92);
   endproperty
   a_rev_keep: assert property (p_rev_keep) else $error("invalid revision stored");

   property p_max_master_reject;
      @(posedge sys_clk) disable iff (!resetn)
      chk_unlock && flag_master && level_max && !any_reset |=> s_aborted and $stable(attempts_left);
   endproperty
   a_max_master_reject: assert property (p_max_master_reject) else $error("master unlock at maximum");

   property p_mismatch_count;
      @(posedge sys_clk) disable iff (!resetn)
      mismatch && !any_reset |=> s_aborted and attempts_left == $past(attempts_left) - 3'h1;
   endproperty
   a_mismatch_count: assert property (p_mismatch_count) else $error("mismatch not counted");

   sequence s_unlock_good;
      chk_unlock && !abort_now && !any_reset;
   endsequence

   property p_unlock_ok;
      @(posedge sys_clk) disable iff (!resetn)
      s_unlock_good |=> !drive_locked && command_status_flags == `ST_READY && state == CMD_IDLE;
   endproperty
   a_unlock_ok: assert property (p_unlock_ok) else $error("good unlock left drive locked");

   property p_reload;
      @(posedge sys_clk) disable iff (!resetn)
      any_reset |=> attempts_left == `ATTEMPTS_INIT && state == CMD_IDLE;
   endproperty
   a_reload: assert property (p_reload) else $error("counter not reloaded");

   property p_sector_len;
      @(posedge sys_clk) disable iff (!resetn)
      state == CMD_XFER && last_word && !any_reset |=> state == CMD_CHECK && command_status_flags == `ST_BUSY;
   endproperty
   a_sector_len: assert property (p_sector_len) else $error("sector end not handled");
endmodule
`default_nettype wire

// >>> verif/ata_host_model.sv
// host side model: issues a command and sends its parameter sector
`timescale 1ns/1ps
`default_nettype none
`include "pwlock_defs.svh"
module ata_host_model #(
   parameter int WORDS = `SECTOR_WORDS
)
(
   // clock
   input wire logic sys_clk,
   // drive answer
   input wire logic [7:0] status,
   // command and data
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic data_valid,
   output logic [15:0] data_word
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      data_valid = 1'b0;
      data_word = 16'h0000;
   end
   task automatic xfer(input logic [7:0] op, input logic [15:0] ctrl, input logic [255:0] pw,
      input logic [15:0] rev);
      @(posedge sys_clk);
      #1 cmd_valid = 1'b1;
      cmd_code = op;
      @(posedge sys_clk);
      #1 cmd_valid = 1'b0;
      cmd_code = ~op;
      // refused or ignored: no sector follows
      if (status !== `ST_XFER)
         return;
      for (int i = 0; i < WORDS; i++)
      begin
         data_valid = 1'b1;
         data_word = i == 0 ? ctrl : i <= 16 ? pw[16*(i-1) +: 16] : i == 17 ? rev : 16'(i);
         @(posedge sys_clk);
         #1;
      end
      // released bus shows no stale word
      data_valid = 1'b0;
      data_word = ~data_word;
      @(posedge sys_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// >>> verif/drive_password_set_unlock_bench.sv
// self-checking bench for the password set and unlock logic
`timescale 1ns/1ps
`default_nettype none
`include "pwlock_defs.svh"
module drive_password_set_unlock_bench;
   typedef struct {
      logic [7:0] op;
      logic [15:0] ctrl;
      int pw;
      logic [15:0] rev;
      logic [7:0] st;
      logic [15:0] w92;
      logic en;
      logic [2:0] att;
   } row_t;
   logic sys_clk;
   logic resetn;
   logic cmd_valid;
   logic [7:0] cmd_code;
   logic data_valid;
   logic [15:0] data_word;
   logic power_on_pulse;
   logic hard_reset_pulse;
   logic frozen;
   logic [7:0] command_error_flags;
   logic [7:0] command_status_flags;
   logic [15:0] identify_word92;
   logic lock_enabled;
   logic drive_locked;
   logic level_max;
   logic [2:0] attempts_left;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   logic [255:0] pw_list [3];
   row_t rows [8];
   drive_password_set_unlock #(.SECTOR_WORDS(20)) dut (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .cmd_valid(cmd_valid),
      .cmd_code(cmd_code),
      .data_valid(data_valid),
      .data_word(data_word),
      .power_on_pulse(power_on_pulse),
      .hard_reset_pulse(hard_reset_pulse),
      .frozen(frozen),
      .command_error_flags(command_error_flags),
      .command_status_flags(command_status_flags),
      .identify_word92(identify_word92),
      .lock_enabled(lock_enabled),
      .drive_locked(drive_locked),
      .level_max(level_max),
      .attempts_left(attempts_left)
   );
   ata_host_model #(.WORDS(20)) host (
      .sys_clk(sys_clk),
      .status(command_status_flags),
      .cmd_valid(cmd_valid),
      .cmd_code(cmd_code),
      .data_valid(data_valid),
      .data_word(data_word)
   );
   task automatic end_of_test();
      $display("counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want)
      begin
         $display("[ERR] %0t saw %h want %h", $time, seen, want);
         mismatches++;
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [15:0] ctrl, input logic [255:0] pw,
      input logic [7:0] st);
      host.xfer(op, ctrl, pw, 16'h0000);
      chk(command_status_flags, st);
      chk(command_error_flags, st === `ST_ABORT ? `ERR_ABORT : `ERR_NONE);
   endtask
   task automatic pulse(input logic hard);
      @(posedge sys_clk);
      #1 power_on_pulse = ~hard;
      hard_reset_pulse = hard;
      @(posedge sys_clk);
      #1 power_on_pulse = 1'b0;
      hard_reset_pulse = 1'b0;
   endtask
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   initial
   begin
      pw_list[0] = {16{16'h5A5A}};
      pw_list[1] = {16{16'h1234}};
      pw_list[2] = pw_list[1] ^ {1'b1, 255'h0};
      rows = '{'{8'hF1, 16'h0001, 0, 16'h0007, 8'h40, 16'h0007, 1'b0, 3'h5},
         '{8'hF1, 16'h0101, 0, 16'hFFFF, 8'h40, 16'h0007, 1'b0, 3'h5},
         '{8'hF1, 16'h0001, 0, 16'h0000, 8'h40, 16'h0007, 1'b0, 3'h5},
         '{8'hF2, 16'h0000, 1, 16'h0000, 8'h41, 16'h0007, 1'b0, 3'h5},
         '{8'hF1, 16'h0000, 1, 16'h1111, 8'h40, 16'h0007, 1'b1, 3'h5},
         '{8'hF2, 16'h0000, 2, 16'h0000, 8'h41, 16'h0007, 1'b1, 3'h4},
         '{8'hF2, 16'h0001, 0, 16'h0000, 8'h40, 16'h0007, 1'b1, 3'h4},
         '{8'hF3, 16'h0000, 1, 16'h0000, 8'h40, 16'h0007, 1'b1, 3'h4}};
      resetn = 1'b0;
      power_on_pulse = 1'b0;
      hard_reset_pulse = 1'b0;
      frozen = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 resetn = 1'b1;
      chk(command_status_flags, `ST_READY);
      chk(identify_word92, `REV_RESET);
      chk(attempts_left, `ATTEMPTS_INIT);
      $display("reset test done");
      foreach (rows[i])
      begin
         host.xfer(rows[i].op, rows[i].ctrl, pw_list[rows[i].pw], rows[i].rev);
         chk(command_status_flags, rows[i].st);
         chk(command_error_flags, rows[i].st === `ST_ABORT ? `ERR_ABORT : `ERR_NONE);
         chk(identify_word92, rows[i].w92);
         chk(lock_enabled, rows[i].en);
         chk(drive_locked, 1'b0);
         chk(attempts_left, rows[i].att);
         $display("row %0d done", i);
      end
      pulse(1'b0);
      chk(drive_locked, 1'b1);
      chk(attempts_left, `ATTEMPTS_INIT);
      cmd(8'hF2, 16'h0000, pw_list[1], `ST_READY);
      chk(drive_locked, 1'b0);
      pulse(1'b1);
      chk(drive_locked, 1'b1);
      $display("relock test done");
      cmd(8'hF1, 16'h0100, pw_list[1], `ST_READY);
      chk(level_max, 1'b1);
      pulse(1'b0);
      cmd(8'hF2, 16'h0001, pw_list[0], `ST_ABORT);
      repeat (5) cmd(8'hF2, 16'h0000, pw_list[2], `ST_ABORT);
      chk(attempts_left, 3'h0);
      cmd(8'hF2, 16'h0000, pw_list[1], `ST_ABORT);
      cmd(8'hF1, 16'h0000, pw_list[1], `ST_ABORT);
      chk(drive_locked, 1'b1);
      pulse(1'b1);
      chk(attempts_left, `ATTEMPTS_INIT);
      cmd(8'hF2, 16'h0000, pw_list[1], `ST_READY);
      $display("maximum level test done");
      frozen = 1'b1;
      cmd(8'hF1, 16'h0000, pw_list[1], `ST_ABORT);
      cmd(8'hF2, 16'h0000, pw_list[1], `ST_ABORT);
      frozen = 1'b0;
      $display("frozen test done");
      resetn = 1'b0;
      #1 chk(lock_enabled, 1'b0);
      chk(attempts_left, `ATTEMPTS_INIT);
      @(posedge sys_clk);
      #1 resetn = 1'b1;
      chk(command_status_flags, `ST_READY);
      chk(identify_word92, `REV_RESET);
      chk(drive_locked, 1'b0);
      cmd(8'hF2, 16'h0000, pw_list[1], `ST_ABORT);
      chk(attempts_left, `ATTEMPTS_INIT);
      $display("second reset test done");
      end_of_test();
   end
endmodule
`default_nettype wire
